// *** common/nmo_consts.svh ***
// Constants for the negative multiply-accumulate and OR-family slice.
// Assumes instruction words arrive with the most significant bit first.
`ifndef NMO_CONSTS_SVH
`define NMO_CONSTS_SVH
`define NMO_W          32
`define NMO_PRIM_HI    31
`define NMO_PRIM_LO    26
`define NMO_RT_HI      25
`define NMO_RT_LO      21
`define NMO_LTGT_HI    20
`define NMO_LTGT_LO    16
`define NMO_OE_BIT     10
`define NMO_XO9_HI     9
`define NMO_XO10_HI    10
`define NMO_XO_LO      1
`define NMO_REC_BIT    0
`define NMO_HALF_HI    31
`define NMO_HALF_MID   16
`define NMO_HALF_LO    15
`define NMO_PRIM_MAC   6'h04
`define NMO_PRIM_X     6'h1F
`define NMO_PRIM_ORI   6'h18
`define NMO_PRIM_ORIS  6'h19
`define NMO_XO_HHWS    9'h06E
`define NMO_XO_LHW     9'h1AE
`define NMO_XO_LHWS    9'h1EE
`define NMO_XO_NOR     10'h07C
`define NMO_XO_OR      10'h1BC
`define NMO_XO_ORC     10'h19C
`define NMO_ZERO16     16'h0000
`define NMO_ZERO32     32'h0000_0000
`endif

// *** common/nmo_pkg.sv ***
// Types shared by the negative multiply-accumulate and OR-family slice.
// Assumes the constants header is compiled alongside.
package nmo_pkg;
  // Operation selected by the decoder.
  typedef enum logic [3:0] {
    NMO_OP_NONE = 4'b0000,
    NMO_OP_HHWS = 4'b0001,
    NMO_OP_LHW  = 4'b0010,
    NMO_OP_LHWS = 4'b0011,
    NMO_OP_NOR  = 4'b0100,
    NMO_OP_OR   = 4'b0101,
    NMO_OP_ORC  = 4'b0110,
    NMO_OP_ORI  = 4'b0111,
    NMO_OP_ORIS = 4'b1000
  } nmo_op_t;

  // Whole registered state of the slice.
  typedef struct packed {
    logic        done;
    logic        illegal;
    logic [31:0] result;
    logic [4:0]  target_idx;
    logic [3:0]  cfz;
    logic        cfz_wr;
    logic        sticky;
    logic        excess;
  } nmo_state_t;
endpackage

// *** design/nmo_alu.sv ***
// Execution slice: negative halfword multiply-accumulate and the OR family.
// Assumes the pipeline gives it register contents read in the issue cycle
// and writes the result back itself; all inputs are on mclk_in.
`include "nmo_consts.svh"

// Functional notes
// - High form multiplies signed upper halfwords.
// - Low forms multiply signed lower halfwords.
// - Negated product plus destination, 33 bits.
// - Modulo form keeps low 32 bits.
// - Saturating, no overflow: keep low bits.
// - Saturating overflow clamps to signed limits.
// - Enable bit governs sticky and excess flags.
// - Record bit updates condition field zero.
// - NOR writes inverted OR of operands.
// - OR writes OR of operands.
// - OR with complement of second operand.
// - OR immediate, zero upper half.
// - OR immediate shifted into upper half.
// - Opcode 4 with 110, 430, 494.
// - Opcode 31 with 124, 444, 412.
// - Opcodes 24, 25 touch only target.
module nmo_alu (
  input  wire logic        mclk_in,          // Core clock, 200 MHz.
  input  wire logic        rst_b_in,         // Asynchronous reset, low.
  input  wire logic        issue_valid_in,   // Instruction offered this cycle.
  input  wire logic [31:0] instr_in,         // Instruction word.
  input  wire logic [31:0] first_src_reg_in, // First source contents.
  input  wire logic [31:0] second_src_reg_in,// Second source contents.
  input  wire logic [31:0] source_reg_in,    // Logic source contents.
  input  wire logic [31:0] dest_in,          // Current destination contents.
  input  wire logic        flags_clear_in,   // Clears sticky and excess flags.
  output logic             done_out,         // Result valid, one cycle.
  output logic             illegal_out,      // Unrecognised word, one cycle.
  output logic [31:0]      result_out,       // Value for the target register.
  output logic [4:0]       target_idx_out,   // Target register number.
  output logic [3:0]       cond_field_zero_out, // LT, GT, EQ, summary.
  output logic             cond_field_zero_wr_out, // Field zero write, pulse.
  output logic             sticky_out,       // Summary overflow flag.
  output logic             excess_flag_out   // Overflow flag of last update.
);
  import nmo_pkg::*;

  // Registered state and its next value.
  nmo_state_t st;
  nmo_state_t next_st;

  // Decoder outputs.
  nmo_op_t     op;            // Selected operation.
  logic [8:0]  xo9;           // Nine-bit extended opcode.
  logic [9:0]  xo10;          // Ten-bit extended opcode.
  logic [5:0]  prim;          // Primary opcode.
  logic        record_bit;    // Record bit of the word.
  logic        oe_bit;        // Overflow-enable bit of the word.
  logic [15:0] unsigned_immediate; // Immediate field.

  // Arithmetic path.
  logic [32:0] mac_sum;       // Intermediate sum, 33 bits.
  logic        mac_ovf;       // Saturation overflow detected.
  logic [31:0] mac_clamp;     // Clamped value on overflow.
  logic [31:0] nprod;         // Negated product.
  logic [31:0] res;           // Selected result.
  logic        is_mac;        // Accumulate family selected.

  // Signed 16 by 16 product, negated; it always fits 32 bits.
  function automatic logic [31:0] neg_prod(input logic [15:0] a,
                                           input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return 32'(-p);
  endfunction

  // Condition field from a signed result and the summary flag.
  function automatic logic [3:0] cond_of(input logic [31:0] v,
                                         input logic so);
    logic lt;
    logic eq;
    lt = v[31];
    eq = (v == `NMO_ZERO32);
    return {lt, !lt && !eq, eq, so};
  endfunction

  // Field extraction from the instruction word.
  always_comb begin
    prim = instr_in[`NMO_PRIM_HI:`NMO_PRIM_LO];
    xo9 = instr_in[`NMO_XO9_HI:`NMO_XO_LO];
    xo10 = instr_in[`NMO_XO10_HI:`NMO_XO_LO];
    record_bit = instr_in[`NMO_REC_BIT];
    oe_bit = instr_in[`NMO_OE_BIT];
    unsigned_immediate = instr_in[`NMO_HALF_LO:0];
  end

  // Decoder; unknown combinations fall to NMO_OP_NONE.
  always_comb begin
    op = NMO_OP_NONE;
    case (prim)
      `NMO_PRIM_MAC: begin
        case (xo9)
          `NMO_XO_HHWS: op = NMO_OP_HHWS;
          `NMO_XO_LHW: op = NMO_OP_LHW;
          `NMO_XO_LHWS: op = NMO_OP_LHWS;
          default: op = NMO_OP_NONE;
        endcase
      end
      `NMO_PRIM_X: begin
        case (xo10)
          `NMO_XO_NOR: op = NMO_OP_NOR;
          `NMO_XO_OR: op = NMO_OP_OR;
          `NMO_XO_ORC: op = NMO_OP_ORC;
          default: op = NMO_OP_NONE;
        endcase
      end
      `NMO_PRIM_ORI: op = NMO_OP_ORI;
      `NMO_PRIM_ORIS: op = NMO_OP_ORIS;
      default: op = NMO_OP_NONE;
    endcase
  end

  // Accumulate datapath; one adder serves all three forms.
  always_comb begin
    is_mac = (op == NMO_OP_HHWS) || (op == NMO_OP_LHW) || (op == NMO_OP_LHWS);
    if (op == NMO_OP_HHWS) begin
      // Upper halves of both sources.
      nprod = neg_prod(first_src_reg_in[`NMO_HALF_HI:`NMO_HALF_MID],
                       second_src_reg_in[`NMO_HALF_HI:`NMO_HALF_MID]);
    end else begin
      // Lower halves of both sources.
      nprod = neg_prod(first_src_reg_in[`NMO_HALF_LO:0],
                       second_src_reg_in[`NMO_HALF_LO:0]);
    end
    // Both operands sign-extended so the top bit is the true sign.
    mac_sum = {nprod[31], nprod} + {dest_in[31], dest_in};
    // Overflow test on operand signs versus the sum's bit 31.
    mac_ovf = (nprod[31] == dest_in[31]) && (mac_sum[31] != dest_in[31]);
    // Sign of the destination followed by 31 inverted copies of it.
    mac_clamp = {dest_in[31], {31{~dest_in[31]}}};
  end

  // Result selection across all operations.
  always_comb begin
    case (op)
      NMO_OP_HHWS,
      NMO_OP_LHWS: res = mac_ovf ? mac_clamp : mac_sum[31:0];
      NMO_OP_LHW: res = mac_sum[31:0];
      NMO_OP_NOR: res = ~(source_reg_in | second_src_reg_in);
      NMO_OP_OR: res = source_reg_in | second_src_reg_in;
      NMO_OP_ORC: res = source_reg_in | ~second_src_reg_in;
      NMO_OP_ORI: res = source_reg_in | {`NMO_ZERO16, unsigned_immediate};
      NMO_OP_ORIS: res = source_reg_in | {unsigned_immediate, `NMO_ZERO16};
      default: res = `NMO_ZERO32;
    endcase
  end

  // Next-state logic. The clear is applied first so that an overflow in
  // the same cycle wins over it and is never lost.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.illegal = 1'b0;
    next_st.cfz_wr = 1'b0;
    if (flags_clear_in) begin
      next_st.sticky = 1'b0;
      next_st.excess = 1'b0;
    end
    if (issue_valid_in) begin
      if (op == NMO_OP_NONE) begin
        // Not ours: flag it and leave every architected value alone.
        next_st.illegal = 1'b1;
      end else begin
        next_st.done = 1'b1;
        next_st.result = res;
        // Accumulate forms name the destination field; logic forms the second field.
        next_st.target_idx = is_mac ? instr_in[`NMO_RT_HI:`NMO_RT_LO]
                                    : instr_in[`NMO_LTGT_HI:`NMO_LTGT_LO];
        // The flags follow the 33-bit overflow for modulo and saturate alike.
        if (is_mac && oe_bit) begin
          next_st.excess = mac_ovf;
          next_st.sticky = next_st.sticky | mac_ovf;
        end
        // Immediate forms carry no record bit and never touch the field.
        if (record_bit && op != NMO_OP_ORI && op != NMO_OP_ORIS) begin
          next_st.cfz = cond_of(res, next_st.sticky);
          next_st.cfz_wr = 1'b1;
        end
      end
    end
  end

  // State register; reset brings the slice up idle with flags clear.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  always_comb begin
    done_out = st.done;
    illegal_out = st.illegal;
    result_out = st.result;
    target_idx_out = st.target_idx;
    cond_field_zero_out = st.cfz;
    cond_field_zero_wr_out = st.cfz_wr;
    sticky_out = st.sticky;
    excess_flag_out = st.excess;
  end

  // Helper: previous-cycle view of the issue for the checks below.
  logic        p_iss;      // Issue was taken last cycle.
  nmo_op_t     p_op;       // Operation taken last cycle.
  logic        p_ovf;      // Overflow seen last cycle.
  logic        p_oe;       // Enable bit last cycle.
  logic        p_rec;      // Record bit last cycle.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      p_iss <= 1'b0;
      p_op <= NMO_OP_NONE;
      p_ovf <= 1'b0;
      p_oe <= 1'b0;
      p_rec <= 1'b0;
    end else begin
      p_iss <= issue_valid_in;
      p_op <= op;
      p_ovf <= mac_ovf;
      p_oe <= oe_bit;
      p_rec <= record_bit;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  // Saturating overflow yields the limit matching the old destination sign.
  a_sat_clamp: assert property (p_iss && (p_op == NMO_OP_HHWS || p_op == NMO_OP_LHWS)
      && p_ovf |-> result_out == {$past(dest_in[31]), {31{~$past(dest_in[31])}}})
    else $error("saturated result is not the signed limit");

  // Modulo form always keeps the low word of the sum.
  a_mod_wrap: assert property (p_iss && p_op == NMO_OP_LHW
      |-> result_out == 32'($past(dest_in) - 32'($signed($past(first_src_reg_in[15:0]))
          * $signed($past(second_src_reg_in[15:0])))))
    else $error("modulo accumulate result is wrong");

  // High form uses the upper halves when no overflow occurs.
  a_high_mult: assert property (p_iss && p_op == NMO_OP_HHWS && !p_ovf
      |-> result_out == 32'($past(dest_in) - 32'($signed($past(first_src_reg_in[31:16]))
          * $signed($past(second_src_reg_in[31:16])))))
    else $error("high halfword accumulate result is wrong");

  // Flags stay put when the enable bit is clear and no clear is pending.
  a_flags_hold: assert property (issue_valid_in && !oe_bit && !flags_clear_in
      |=> $stable(sticky_out) && $stable(excess_flag_out))
    else $error("flags moved with the enable bit clear");

  // Overflow with the enable bit sets both flags even under a clear.
  a_flags_set: assert property (issue_valid_in && is_mac && oe_bit && mac_ovf
      |=> sticky_out && excess_flag_out)
    else $error("overflow did not set the flags");

  // Field zero is written exactly when a recording register form retires.
  a_rec_write: assert property (done_out && (p_op != NMO_OP_ORI && p_op != NMO_OP_ORIS)
      |-> cond_field_zero_wr_out == p_rec)
    else $error("record bit and field write disagree");

  // The written field reflects the sign of the result.
  a_rec_value: assert property (cond_field_zero_wr_out
      |-> cond_field_zero_out[3] == result_out[31]
          && cond_field_zero_out[1] == (result_out == 32'h0000_0000))
    else $error("condition field does not match result");

  // NOR result is the inverted OR of the operands.
  a_nor_value: assert property (p_iss && p_op == NMO_OP_NOR
      |-> result_out == ~($past(source_reg_in) | $past(second_src_reg_in)))
    else $error("nor result is wrong");

  // OR-immediate-shifted places the immediate in the upper half.
  a_oris_value: assert property (p_iss && p_op == NMO_OP_ORIS
      |-> result_out == ($past(source_reg_in) | {$past(instr_in[15:0]), 16'h0000}))
    else $error("or immediate shifted result is wrong");

  // Immediate forms never write the condition field.
  a_imm_noflag: assert property (issue_valid_in && (op == NMO_OP_ORI || op == NMO_OP_ORIS)
      |=> !cond_field_zero_wr_out ##0 done_out)
    else $error("immediate form touched the condition field");

  // Low saturating form uses the lower halves when no overflow occurs.
  a_low_mult: assert property (p_iss && p_op == NMO_OP_LHWS && !p_ovf
      |-> result_out == 32'($past(dest_in) - 32'($signed($past(first_src_reg_in[15:0]))
          * $signed($past(second_src_reg_in[15:0])))))
    else $error("low halfword saturating result is wrong");

  // OR result is the plain OR of the operands.
  a_or_value: assert property (p_iss && p_op == NMO_OP_OR
      |-> result_out == ($past(source_reg_in) | $past(second_src_reg_in)))
    else $error("or result is wrong");

  // OR with complement inverts only the second operand.
  a_orc_value: assert property (p_iss && p_op == NMO_OP_ORC
      |-> result_out == ($past(source_reg_in) | ~$past(second_src_reg_in)))
    else $error("or with complement result is wrong");

  // OR-immediate keeps the upper half of the source untouched.
  a_ori_value: assert property (p_iss && p_op == NMO_OP_ORI
      |-> result_out == ($past(source_reg_in) | {16'h0000, $past(instr_in[15:0])}))
    else $error("or immediate result is wrong");

  // A refused word pulses the refusal and leaves the result, sticky flag and condition field alone.
  // A clear in the same cycle is excluded, since it may legally move the flags.
  a_illegal_hold: assert property (issue_valid_in && op == NMO_OP_NONE
      && !flags_clear_in |=> illegal_out && !done_out && $stable(result_out)
          && $stable(sticky_out) && $stable(cond_field_zero_out))
    else $error("refused word changed state");

  // Accumulate forms write back to the destination field of the word.
  a_mac_target: assert property (p_iss
      && p_op inside {NMO_OP_HHWS, NMO_OP_LHW, NMO_OP_LHWS}
      |-> target_idx_out == $past(instr_in[25:21]))
    else $error("accumulate target field is wrong");

  // An enabled accumulate without overflow clears the excess flag.
  a_excess_drop: assert property (issue_valid_in && is_mac && oe_bit && !mac_ovf
      |=> !excess_flag_out)
    else $error("excess flag not cleared by a clean accumulate");

  // A clear with no enabled accumulate beside it empties both flags.
  a_flag_clear: assert property (flags_clear_in
      && !(issue_valid_in && is_mac && oe_bit) |=> !sticky_out && !excess_flag_out)
    else $error("flag clear did not empty the flags");

  // The summary bit of the field copies the sticky flag after the update.
  a_cond_so: assert property (cond_field_zero_wr_out
      |-> cond_field_zero_out[0] == sticky_out)
    else $error("summary bit of the field disagrees with the sticky flag");

  c_sat_hit: cover property (done_out && p_op == NMO_OP_LHWS && p_ovf);
  c_rec_or: cover property (cond_field_zero_wr_out && p_op == NMO_OP_OR);
  c_clear_race: cover property (flags_clear_in && issue_valid_in && oe_bit && mac_ovf);
  c_illegal: cover property (illegal_out);
  c_low_mod: cover property (done_out && p_op == NMO_OP_LHW && p_ovf);
endmodule

// *** tb/nmo_pipe_model.sv ***
// Writeback side of the pipeline: stores each result that the slice hands over.
// Assumes done_in is a one-cycle pulse that qualifies idx_in and val_in.
module nmo_pipe_model (
  input  wire logic        clk_in,       // Core clock.
  input  wire logic        rst_b_in,     // Asynchronous reset, low.
  input  wire logic        done_in,      // Result valid pulse.
  input  wire logic [4:0]  idx_in,       // Target register number.
  input  wire logic [31:0] val_in,       // Value to store.
  input  wire logic [4:0]  rd_idx_in,    // Register looked at by the bench.
  output logic      [31:0] rd_val_out,   // Contents of that register.
  output logic      [15:0] wb_count_out  // Number of writebacks taken.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] gpr [32]; // Register file; left unreset, as in a real core.

  // Lookup is combinational so the bench sees a write one edge after done.
  assign rd_val_out = gpr[rd_idx_in];

  // The count shows a stray done pulse, which a value check alone would miss.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_count_out <= 16'h0000;
    end else if (done_in) begin
      wb_count_out <= wb_count_out + 16'h0001;
    end
  end

  // Store the result at the target index.
  always_ff @(posedge clk_in) begin
    if (done_in) begin
      gpr[idx_in] <= val_in;
    end
  end
endmodule

// *** tb/tb_nmo_alu.sv ***
// Self-checking bench for the multiply-accumulate and OR-family slice.
// Assumes the slice answers one cycle after each taken word and never stalls.
`include "nmo_consts.svh"
module tb_nmo_alu;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in = 1'b0;            // Core clock, 5 ns period.
  logic        rst_b_in = 1'b0;           // Reset, low.
  logic        issue_valid_in = 1'b0;     // Offer strobe.
  logic        flags_clear_in = 1'b0;     // Flag clear strobe.
  logic [31:0] instr_in = `NMO_ZERO32;    // Word offered.
  logic [31:0] first_src_reg_in = `NMO_ZERO32;
  logic [31:0] second_src_reg_in = `NMO_ZERO32;
  logic [31:0] source_reg_in = `NMO_ZERO32;
  logic [31:0] dest_in = `NMO_ZERO32;
  logic [4:0]  rd_idx = 5'h15;            // Register read back at the end.
  logic        done_out, illegal_out, cond_field_zero_wr_out, sticky_out, excess_flag_out;
  logic [31:0] result_out, rd_val;
  logic [4:0]  target_idx_out;
  logic [3:0]  cond_field_zero_out;
  logic [15:0] wb_count;
  logic [31:0] e_res = `NMO_ZERO32;       // Expected outputs, kept by the bench.
  logic [4:0]  e_tgt = 5'h00;
  logic [3:0]  e_cf = 4'h0;
  logic        e_stk = 1'b0;
  logic        e_exc = 1'b0;
  logic        race = 1'b0;             // Offer a flag clear with each word while set.
  int          fails = 0;
  int          checks_done = 0;
  int          wb_exp = 0;
  int          cyc = 0;

  nmo_alu i_nmo_alu (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .issue_valid_in(issue_valid_in),
    .instr_in(instr_in), .first_src_reg_in(first_src_reg_in),
    .second_src_reg_in(second_src_reg_in), .source_reg_in(source_reg_in), .dest_in(dest_in),
    .flags_clear_in(flags_clear_in), .done_out(done_out), .illegal_out(illegal_out),
    .result_out(result_out), .target_idx_out(target_idx_out),
    .cond_field_zero_out(cond_field_zero_out), .cond_field_zero_wr_out(cond_field_zero_wr_out),
    .sticky_out(sticky_out), .excess_flag_out(excess_flag_out));

  nmo_pipe_model i_nmo_pipe_model (.clk_in(mclk_in), .rst_b_in(rst_b_in), .done_in(done_out),
    .idx_in(target_idx_out), .val_in(result_out), .rd_idx_in(rd_idx), .rd_val_out(rd_val),
    .wb_count_out(wb_count));

  // Free-running clock.
  always #2.5 mclk_in = ~mclk_in;

  // A hang is cut short well beyond the 44 cycles the tests need.
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_of_test();
    end
  end

  // Compare one value and count it.
  task automatic check(input logic [31:0] seen, want, input string what);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  // Offer one word for one cycle and check everything one edge after it is taken.
  task automatic issue(input logic [31:0] w, a, b, s, d, input logic [4:0] tg,
                       input logic upd, input logic [31:0] r, input logic ok);
    @(posedge mclk_in);
    #1;
    issue_valid_in = 1'b1;
    instr_in = w;
    first_src_reg_in = a;
    second_src_reg_in = b;
    source_reg_in = s;
    dest_in = d;
    flags_clear_in = race;
    @(posedge mclk_in);
    #1;
    issue_valid_in = 1'b0;
    flags_clear_in = 1'b0;
    if (ok) begin
      e_res = r;
      e_tgt = tg;
      wb_exp++;
      if (upd) e_cf = {r[31], !r[31] && (r != `NMO_ZERO32), r == `NMO_ZERO32, e_stk};
    end
    check(done_out, ok, "done");
    check(illegal_out, !ok, "illegal");
    check(result_out, e_res, "result");
    check(target_idx_out, e_tgt, "target");
    check(cond_field_zero_wr_out, ok && upd, "cond write");
    check(cond_field_zero_out, e_cf, "cond field");
    check({sticky_out, excess_flag_out}, {e_stk, e_exc}, "flags");
  endtask

  // Accumulate form: the bench works out the product, sum and clamp itself.
  task automatic mac(input logic [8:0] xo, input logic oe, rec, input logic [31:0] a, b, d);
    logic signed [15:0] x, y;
    logic [31:0] np, r;
    logic [32:0] t;
    logic ovf;
    x = (xo == `NMO_XO_HHWS) ? a[31:16] : a[15:0];
    y = (xo == `NMO_XO_HHWS) ? b[31:16] : b[15:0];
    np = -(x * y);
    t = {np[31], np} + {d[31], d};
    ovf = (np[31] == d[31]) && (t[31] != d[31]);
    r = (ovf && xo != `NMO_XO_LHW) ? {d[31], {31{~d[31]}}} : t[31:0];
    // A clear offered with the word empties the flags; an overflow then wins.
    if (race) begin
      e_stk = 1'b0;
      e_exc = 1'b0;
    end
    if (oe) begin
      e_exc = ovf;
      e_stk = e_stk | ovf;
    end
    issue({`NMO_PRIM_MAC, 5'h0A, 5'h15, 5'h03, oe, xo, rec}, a, b, 32'h3C3C_3C3C, d, 5'h0A,
          rec, r, 1'b1);
  endtask

  // Register logic form; the unused operands carry patterns that must not leak.
  task automatic lop(input logic [9:0] xo, input logic rec, input logic [31:0] s, b);
    logic [31:0] r;
    r = (xo == `NMO_XO_NOR) ? ~(s | b) : (xo == `NMO_XO_OR) ? (s | b) : (s | ~b);
    issue({`NMO_PRIM_X, 5'h0A, 5'h15, 5'h03, xo, rec}, 32'h5A5A_5A5A, b, s, 32'hA5A5_A5A5,
          5'h15, rec, r, 1'b1);
  endtask

  // Pulse the flag clear for one cycle.
  task automatic clr();
    @(posedge mclk_in);
    #1;
    flags_clear_in = 1'b1;
    @(posedge mclk_in);
    #1;
    flags_clear_in = 1'b0;
    e_stk = 1'b0;
    e_exc = 1'b0;
    check({sticky_out, excess_flag_out}, 2'b00, "flag clear");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: reset, accumulate, logic, immediate and refused words.
  initial begin
    repeat (10) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    check({done_out, illegal_out, cond_field_zero_wr_out, sticky_out, excess_flag_out},
          0, "rst");
    check({result_out, target_idx_out, cond_field_zero_out}, 0, "reset values");
    $display("test reset done");
    mac(`NMO_XO_HHWS, 1'b1, 1'b1, 32'h0003_7FFF, 32'h0004_8000, 32'h0000_0100);
    mac(`NMO_XO_HHWS, 1'b1, 1'b1, 32'h8000_0001, 32'h0001_7FFF, 32'h7FFF_FFF0);
    mac(`NMO_XO_LHW, 1'b1, 1'b0, 32'h7FFF_0100, 32'h8000_0100, 32'h8000_0010);
    mac(`NMO_XO_LHWS, 1'b1, 1'b1, 32'h7FFF_0100, 32'h8000_0100, 32'h8000_0010);
    mac(`NMO_XO_LHWS, 1'b1, 1'b1, 32'h0000_FFFF, 32'h0000_0002, 32'h0000_0001);
    clr();
    mac(`NMO_XO_LHWS, 1'b0, 1'b1, 32'h7FFF_0100, 32'h8000_0100, 32'h8000_0010);
    race = 1'b1;
    mac(`NMO_XO_LHWS, 1'b1, 1'b1, 32'h7FFF_0100, 32'h8000_0100, 32'h8000_0010);
    mac(`NMO_XO_LHWS, 1'b1, 1'b0, 32'h0000_FFFF, 32'h0000_0002, 32'h0000_0001);
    race = 1'b0;
    $display("test accumulate done");
    lop(`NMO_XO_NOR, 1'b1, 32'h0F0F_00F0, 32'h00FF_0F00);
    lop(`NMO_XO_NOR, 1'b1, 32'h8000_0000, 32'h8000_0000);
    lop(`NMO_XO_OR, 1'b0, 32'h0F0F_00F0, 32'h00FF_0F00);
    lop(`NMO_XO_ORC, 1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test logic done");
    issue({`NMO_PRIM_ORI, 5'h0A, 5'h15, 16'h8001}, 32'h1, 32'h2, 32'h1200_0030, 32'h4, 5'h15,
          1'b0, 32'h1200_8031, 1'b1);
    issue({`NMO_PRIM_ORIS, 5'h0A, 5'h15, 16'h8001}, 32'h1, 32'h2, 32'h1200_0030, 32'h4, 5'h15,
          1'b0, 32'h9201_0030, 1'b1);
    $display("test immediate done");
    issue({`NMO_PRIM_MAC, 5'h0A, 5'h15, 5'h03, 1'b1, 9'h02E, 1'b1}, 32'h1, 32'h2, 32'h3,
          32'h4, 5'h00, 1'b0, 32'h0, 1'b0);
    issue({`NMO_PRIM_X, 5'h0A, 5'h15, 5'h03, 10'h1DC, 1'b1}, 32'h1, 32'h2, 32'h3, 32'h4,
          5'h00, 1'b0, 32'h0, 1'b0);
    check(wb_count, wb_exp, "writeback count");
    check(rd_val, 32'h9201_0030, "written register");
    $display("test refused done");
    end_of_test();
  end
endmodule
